// ===== aamc_conv_model.sv
// Converter model: takes a request, acknowledges it, returns one sample
`timescale 1ns/1ns
module aamc_conv_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Request and answer
    input  wire logic       slow,
    input  wire logic       req,
    input  wire logic [7:0] sample,
    output logic            ack,
    output logic            done,
    output logic      [7:0] data
);
    logic [3:0] cnt_q;
    // Busy for a full count so one request is never taken twice
    always_ff @(posedge clk) begin
        if (rst) cnt_q <= 4'h0;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q + 4'h1;
        else if (req) cnt_q <= 4'h1;
    end
    assign ack  = (cnt_q == (slow ? 4'h5 : 4'h2));
    assign done = (cnt_q == (slow ? 4'hB : 4'h4));
    // Outside the done cycle the data lines show the inverse
    assign data = done ? sample : ~sample;
endmodule : aamc_conv_model

// ===== aamc_interval.sv
// Minute-interval timer for one background conversion channel
`timescale 1ns/1ns
module aamc_interval (
    // Clock, reset and enable
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Timebase and configuration
    input  wire logic       minute_tick,
    input  wire logic [4:0] period_min,
    // Result
    output logic            due
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic       due_d;

    // Zero period disables the channel and holds the counter at rest
    always_comb begin
        cnt_d = cnt_q;
        due_d = 1'b0;
        if (period_min == 5'h00) begin
            cnt_d = 5'h00;
        end else if (minute_tick) begin
            if (cnt_q + 5'h01 >= period_min) begin
                cnt_d = 5'h00;
                due_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 5'h00;
            due   <= 1'b0;
        end else if (ce) begin
            cnt_q <= cnt_d;
            due   <= due_d;
        end
    end
endmodule : aamc_interval

// ===== aamc_pkg.sv
// Package: register map, field positions and timing for the aux converter control
// ----------------------------------------------------------------------------
// Operation
// R01: Writing one to start bit 7 clears the PLL fault indication.
// R02: Start bit 1 requests a temperature conversion; clears when converter accepts.
// R03: Start bit 0 requests a battery conversion; clears when converter accepts.
// R04: Start bit 2 requests an external-voltage conversion; self-clears on accept.
// R05: Battery result strictly below low threshold raises the battery interrupt.
// R06: Temperature result register loads only when temperature interrupt fires.
// R07: Temperature result is eight bits, 0.78 degC per LSB.
// R08: Finished software temperature conversion loads result and interrupts.
// R09: Background temperature conversions off after reset; need nonzero interval.
// R10: Temperature interval: 00 none, 01 8 min, 10 2 min, 11 1 min.
// R11: Background temperature interrupts only when change from last exceeds delta.
// R12: Delta code 000 never, 001-110 LSB threshold, 111 every conversion.
// R13: Software runs single conversion, sets delta, then sets interval.
// R14: Temperature: full power both, battery single only, halted background only.
// R15: Temperature interrupt has no readable or clearable flag.
// R16: Battery result is eight bits, 14.6 mV per LSB.
// R17: Finished software battery conversion loads result and interrupts.
// R18: Low background battery sets flag; interrupt only if enable bit set.
// R19: Battery interval: 00 none, 01 16 min, 10 4 min, 11 1 min.
// R20: Battery: full power both, battery single only, halted none.
// R21: Ready single battery conversion also sets the low-battery flag.
// R22: Battery result register updates only when low-battery flag sets.
// R23: Software sets battery threshold before battery interval.
// R24: Background intervals derive from the always-running timebase.
// ----------------------------------------------------------------------------
package aamc_pkg;
    // Register offsets
    localparam logic [7:0] OFS_TEMP_RESULT = 8'hD7;
    localparam logic [7:0] OFS_ADC_START   = 8'hD8;
    localparam logic [7:0] OFS_BATT_RESULT = 8'hDF;
    localparam logic [7:0] OFS_EXT_RESULT  = 8'hEF;
    localparam logic [7:0] OFS_DELTA_CFG   = 8'hF3;
    localparam logic [7:0] OFS_STROBE_PER  = 8'hF9;
    localparam logic [7:0] OFS_LOW_BATT_TH = 8'hFA;
    // Start register bits
    localparam int BIT_BATT_START = 0;
    localparam int BIT_TEMP_START = 1;
    localparam int BIT_EXT_START  = 2;
    localparam int BIT_PLL_ACK    = 7;
    // Field positions
    localparam int TEMP_DELTA_LSB  = 3;
    localparam int TEMP_PER_LSB    = 0;
    localparam int BATT_PER_LSB    = 2;
    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;
    // Delta code that interrupts on every conversion
    localparam logic [2:0] DELTA_EVERY = 3'h7;
    // Intervals in minutes
    localparam logic [4:0] TEMP_MIN_01 = 5'h08;
    localparam logic [4:0] TEMP_MIN_10 = 5'h02;
    localparam logic [4:0] TEMP_MIN_11 = 5'h01;
    localparam logic [4:0] BATT_MIN_01 = 5'h10;
    localparam logic [4:0] BATT_MIN_10 = 5'h04;
    localparam logic [4:0] BATT_MIN_11 = 5'h01;
    // Timebase: one minute tick expected from the always-on RTC
    localparam int SEC_PER_MIN = 60;

    typedef enum logic [1:0] {
        PM_FULL   = 2'b00,
        PM_BATT   = 2'b01,
        PM_HALTED = 2'b10
    } aamc_mode_e;
endpackage : aamc_pkg

// ===== aamc_top.sv
// Auxiliary converter measurement control: start bits, results, compares
`timescale 1ns/1ns
module aamc_top (
    // Clock, reset, enable
    input  wire logic       SYS_CLK,
    input  wire logic       RST,
    input  wire logic       CE,
    // Register port
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    // Power mode and timebase
    input  wire logic [1:0] POWER_MODE,
    input  wire logic       MINUTE_TICK,
    // PLL fault
    input  wire logic       PLL_FAULT_SET,
    output logic            PLL_FAULT_INDICATION,
    // Power-management flag handshake
    input  wire logic       LOW_BATT_IRQ_ENABLE,
    input  wire logic       LOW_BATT_FLAG_CLR,
    output logic            LOW_BATT_FLAG,
    output logic            POWER_IRQ,
    // Temperature converter
    output logic            TEMP_REQ,
    input  wire logic       TEMP_ACK,
    input  wire logic       TEMP_DONE,
    input  wire logic [7:0] TEMP_DATA,
    output logic            TEMP_IRQ,
    // Battery converter
    output logic            BATT_REQ,
    input  wire logic       BATT_ACK,
    input  wire logic       BATT_DONE,
    input  wire logic [7:0] BATT_DATA,
    output logic            BATT_IRQ,
    // External-voltage converter
    output logic            EXT_REQ,
    input  wire logic       EXT_ACK,
    input  wire logic       EXT_DONE,
    input  wire logic [7:0] EXT_DATA,
    output logic            EXT_IRQ
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic [7:0] temp_result_q,   temp_result_d;
    logic [7:0] temp_last_q,     temp_last_d;
    logic [7:0] batt_result_q,   batt_result_d;
    logic [7:0] ext_result_q,    ext_result_d;
    logic [7:0] delta_q,         delta_d;
    logic [7:0] strobe_q,        strobe_d;
    logic [7:0] low_th_q,        low_th_d;
    logic [2:0] start_q,         start_d;
    logic       temp_bg_q,       temp_bg_d;
    logic       batt_bg_q,       batt_bg_d;
    logic       temp_sw_q,       temp_sw_d;
    logic       batt_sw_q,       batt_sw_d;
    logic       pll_q,           pll_d;
    logic       flag_q,          flag_d;
    logic       pirq_d, tirq_d, birq_d, eirq_d;
    logic [7:0] rdata_d;
    logic       temp_due, batt_due, temp_int, batt_low;
    logic [4:0] temp_per, batt_per;
    logic [2:0] temp_delta;
    logic       mode_full, mode_batt, mode_halt;

    // Absolute difference, used for the delta compare
    function automatic logic [7:0] abs_diff(input logic [7:0] a,
                                            input logic [7:0] b);
        abs_diff = (a >= b) ? (a - b) : (b - a);
    endfunction : abs_diff
    // Decode a two-bit period field into minutes
    function automatic logic [4:0] per_dec(input logic [1:0] code,
                                           input logic       is_batt);
        unique case (code)
            2'b00: per_dec = 5'h00;
            2'b01: per_dec = is_batt ? aamc_pkg::BATT_MIN_01
                                     : aamc_pkg::TEMP_MIN_01;
            2'b10: per_dec = is_batt ? aamc_pkg::BATT_MIN_10
                                     : aamc_pkg::TEMP_MIN_10;
            2'b11: per_dec = is_batt ? aamc_pkg::BATT_MIN_11
                                     : aamc_pkg::TEMP_MIN_11;
        endcase
    endfunction : per_dec
    assign mode_full = (POWER_MODE == aamc_pkg::PM_FULL);
    assign mode_batt = (POWER_MODE == aamc_pkg::PM_BATT);
    assign mode_halt = (POWER_MODE == aamc_pkg::PM_HALTED);

    // Background periods only run where the mode allows them
    assign temp_per = (mode_full || mode_halt)                        // R14
        ? per_dec(strobe_q[aamc_pkg::TEMP_PER_LSB +: 2], 1'b0) : 5'h00; // R10
    assign batt_per = mode_full                                       // R20
        ? per_dec(strobe_q[aamc_pkg::BATT_PER_LSB +: 2], 1'b1) : 5'h00; // R19
    assign temp_delta = delta_q[aamc_pkg::TEMP_DELTA_LSB +: 3];

    // ------------------------------------------------------------------------
    // Interval timers on the always-on minute tick
    // ------------------------------------------------------------------------
    aamc_interval u_temp_iv (                                        // R24
        .clk         (SYS_CLK),
        .rst         (RST),
        .ce          (CE),
        .minute_tick (MINUTE_TICK),
        .period_min  (temp_per),
        .due         (temp_due)
    );
    aamc_interval u_batt_iv (
        .clk         (SYS_CLK),
        .rst         (RST),
        .ce          (CE),
        .minute_tick (MINUTE_TICK),
        .period_min  (batt_per),
        .due         (batt_due)
    );

    // ------------------------------------------------------------------------
    // Compare decisions on a completed conversion
    // ------------------------------------------------------------------------
    // Background temperature: 000 never, 111 always, else strict exceed
    always_comb begin
        temp_int = 1'b0;
        if (TEMP_DONE) begin
            if (temp_sw_q) begin
                temp_int = 1'b1;                                      // R08
            end else if (temp_delta == aamc_pkg::DELTA_EVERY) begin
                temp_int = 1'b1;                                      // R12
            end else if (temp_delta != 3'h0) begin
                temp_int = abs_diff(TEMP_DATA, temp_last_q)          // R11
                           > {5'h00, temp_delta};
            end
        end
    end
    assign batt_low = BATT_DONE && (BATT_DATA < low_th_q);           // R05

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        temp_result_d = temp_result_q;
        temp_last_d   = temp_last_q;
        batt_result_d = batt_result_q;
        ext_result_d  = ext_result_q;
        delta_d       = delta_q;
        strobe_d      = strobe_q;
        low_th_d      = low_th_q;
        start_d       = start_q;
        temp_bg_d     = temp_bg_q;
        batt_bg_d     = batt_bg_q;
        temp_sw_d     = temp_sw_q;
        batt_sw_d     = batt_sw_q;
        pll_d         = pll_q;
        flag_d        = flag_q;
        tirq_d        = 1'b0;
        birq_d        = 1'b0;
        eirq_d        = 1'b0;
        // Software writes; halted processor cannot write start bits
        if (REG_WR) begin
            unique case (REG_ADDR)
                aamc_pkg::OFS_ADC_START: begin
                    if (!mode_halt) begin                             // R14
                        start_d = start_q | REG_WDATA[2:0];           // R02
                    end
                    if (REG_WDATA[aamc_pkg::BIT_PLL_ACK]) begin
                        pll_d = 1'b0;                                 // R01
                    end
                end
                aamc_pkg::OFS_DELTA_CFG:   delta_d  = REG_WDATA & 8'h3F;
                aamc_pkg::OFS_STROBE_PER:  strobe_d = REG_WDATA;
                aamc_pkg::OFS_LOW_BATT_TH: low_th_d = REG_WDATA;
                default: ;
            endcase
        end
        pll_d = pll_d || PLL_FAULT_SET;
        // Accept handshakes self-clear the start bits
        if (TEMP_ACK && start_q[aamc_pkg::BIT_TEMP_START]) begin
            start_d[aamc_pkg::BIT_TEMP_START] = 1'b0;                 // R02
            temp_sw_d = 1'b1;
        end else if (TEMP_ACK && temp_bg_q) begin
            temp_bg_d = 1'b0;
        end
        temp_bg_d = temp_bg_d || temp_due;                            // R09
        if (BATT_ACK && start_q[aamc_pkg::BIT_BATT_START]) begin
            start_d[aamc_pkg::BIT_BATT_START] = 1'b0;                 // R03
            batt_sw_d = 1'b1;
        end else if (BATT_ACK && batt_bg_q) begin
            batt_bg_d = 1'b0;
        end
        batt_bg_d = batt_bg_d || batt_due;
        if (EXT_ACK && start_q[aamc_pkg::BIT_EXT_START]) begin
            start_d[aamc_pkg::BIT_EXT_START] = 1'b0;                  // R04
        end
        // Temperature completion; no readable flag exists for it
        if (TEMP_DONE) begin
            temp_sw_d = 1'b0;
            if (temp_int) begin
                temp_result_d = TEMP_DATA;                            // R06
                temp_last_d   = TEMP_DATA;
                tirq_d        = 1'b1;                                 // R15
            end
        end
        // Clear first, so a setting completion in the same cycle wins
        if (LOW_BATT_FLAG_CLR) begin
            flag_d = 1'b0;
        end
        if (BATT_DONE) begin
            batt_sw_d = 1'b0;
            if (batt_low || batt_sw_q) begin
                flag_d        = 1'b1;                                 // R21
                batt_result_d = BATT_DATA;                            // R22
                birq_d        = 1'b1;                                 // R17
            end
        end
        if (EXT_DONE && start_q[aamc_pkg::BIT_EXT_START] == 1'b0) begin
            ext_result_d = EXT_DATA;
            eirq_d       = 1'b1;
        end
        pirq_d = flag_d && LOW_BATT_IRQ_ENABLE;                       // R18
    end

    // Read mux; start bits read back pending requests
    always_comb begin
        rdata_d = 8'h00;
        if (REG_RD) begin
            unique case (REG_ADDR)
                aamc_pkg::OFS_TEMP_RESULT: rdata_d = temp_result_q;  // R07
                aamc_pkg::OFS_ADC_START:   rdata_d = {5'h00, start_q};
                aamc_pkg::OFS_BATT_RESULT: rdata_d = batt_result_q;  // R16
                aamc_pkg::OFS_EXT_RESULT:  rdata_d = ext_result_q;
                aamc_pkg::OFS_DELTA_CFG:   rdata_d = delta_q;
                aamc_pkg::OFS_STROBE_PER:  rdata_d = strobe_q;
                aamc_pkg::OFS_LOW_BATT_TH: rdata_d = low_th_q;
                default:                   rdata_d = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            temp_result_q        <= aamc_pkg::RST_REG;
            temp_last_q          <= aamc_pkg::RST_REG;
            batt_result_q        <= aamc_pkg::RST_REG;
            ext_result_q         <= aamc_pkg::RST_REG;
            delta_q              <= aamc_pkg::RST_REG;
            strobe_q             <= aamc_pkg::RST_REG;                // R09
            low_th_q             <= aamc_pkg::RST_REG;
            start_q              <= 3'h0;
            temp_bg_q            <= 1'b0;
            batt_bg_q            <= 1'b0;
            temp_sw_q            <= 1'b0;
            batt_sw_q            <= 1'b0;
            pll_q                <= 1'b0;
            flag_q               <= 1'b0;
            REG_RDATA            <= 8'h00;
            PLL_FAULT_INDICATION <= 1'b0;
            LOW_BATT_FLAG        <= 1'b0;
            POWER_IRQ            <= 1'b0;
            TEMP_REQ             <= 1'b0;
            BATT_REQ             <= 1'b0;
            EXT_REQ              <= 1'b0;
            TEMP_IRQ             <= 1'b0;
            BATT_IRQ             <= 1'b0;
            EXT_IRQ              <= 1'b0;
        end else if (CE) begin
            temp_result_q        <= temp_result_d;
            temp_last_q          <= temp_last_d;
            batt_result_q        <= batt_result_d;
            ext_result_q         <= ext_result_d;
            delta_q              <= delta_d;
            strobe_q             <= strobe_d;
            low_th_q             <= low_th_d;
            start_q              <= start_d;
            temp_bg_q            <= temp_bg_d;
            batt_bg_q            <= batt_bg_d;
            temp_sw_q            <= temp_sw_d;
            batt_sw_q            <= batt_sw_d;
            pll_q                <= pll_d;
            flag_q               <= flag_d;
            REG_RDATA            <= rdata_d;
            PLL_FAULT_INDICATION <= pll_d;
            LOW_BATT_FLAG        <= flag_d;
            POWER_IRQ            <= pirq_d;
            TEMP_REQ  <= start_d[aamc_pkg::BIT_TEMP_START] | temp_bg_d;
            BATT_REQ  <= !mode_halt                                   // R20
                         && (start_d[aamc_pkg::BIT_BATT_START] | batt_bg_d);
            EXT_REQ   <= start_d[aamc_pkg::BIT_EXT_START];
            TEMP_IRQ  <= tirq_d;
            BATT_IRQ  <= birq_d;
            EXT_IRQ   <= eirq_d;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    pll_ack_clear_a: assert property (                                // R01
        CE && REG_WR && REG_ADDR == aamc_pkg::OFS_ADC_START
        && REG_WDATA[7] && !PLL_FAULT_SET |=> !PLL_FAULT_INDICATION)
        else $error("PLL fault not cleared by ack");
    temp_start_clear_a: assert property (                             // R02
        CE && TEMP_ACK && start_q[1] |=> !start_q[1])
        else $error("Temperature start bit did not self-clear");
    batt_start_clear_a: assert property (                             // R03
        CE && BATT_ACK && start_q[0] |=> !start_q[0])
        else $error("Battery start bit did not self-clear");
    ext_start_clear_a: assert property (                              // R04
        CE && EXT_ACK && start_q[2] |=> !start_q[2])
        else $error("External start bit did not self-clear");
    batt_low_irq_a: assert property (                                 // R05
        CE && BATT_DONE && BATT_DATA < low_th_q |=> BATT_IRQ && LOW_BATT_FLAG)
        else $error("Low battery compare missed");
    temp_hold_a: assert property (                                    // R06
        CE && !TEMP_IRQ ##1 CE && !TEMP_IRQ |-> $stable(temp_result_q))
        else $error("Temperature result changed without interrupt");
    temp_sw_irq_a: assert property (                                  // R08
        CE && TEMP_DONE && temp_sw_q |=> TEMP_IRQ
        && temp_result_q == $past(TEMP_DATA))
        else $error("Software temperature conversion not reported");
    batt_halt_a: assert property (                                    // R20
        CE && mode_halt |=> !BATT_REQ)
        else $error("Battery background active while halted");
    delta_zero_a: assert property (                                   // R12
        CE && TEMP_DONE && !temp_sw_q && temp_delta == 3'h0 |=> !TEMP_IRQ)
        else $error("Delta zero still interrupted");
    batt_result_a: assert property (                                  // R22
        CE ##1 $changed(batt_result_q) |-> BATT_IRQ)
        else $error("Battery result changed without flag set");
    power_irq_a: assert property (                                    // R18
        POWER_IRQ |-> LOW_BATT_FLAG && $past(LOW_BATT_IRQ_ENABLE))
        else $error("Power interrupt without enabled flag");
endmodule : aamc_top

// ===== tb_aux_adc_measurement_control.sv
// Self-checking bench for the aux converter control
`timescale 1ns/1ns
module tb_aux_adc_measurement_control;
    logic        sys_clk = 0, rst = 1, wr = 0, rd = 0, tick = 0, slow = 0;
    logic        pset = 0, fclr = 0, pen = 1, pll, flag, pirq, got;
    logic [1:0]  mode = 2'h0;
    logic [7:0]  addr = 8'h00, wd = 8'h00, rdata, td, bd, ed;
    logic [7:0]  ts = 8'h00, bs = 8'h00, es = 8'h00;
    logic        tq, ta, tn, ti, bq, ba, bn, bi, eq, ea, en, ei;
    logic [31:0] lf = 32'h056E;
    int          n_mismatch = 0, n_tests = 0, cyc = 0, m_temp = 0, dir;
    logic [7:0]  ra [6] = '{8'hD7, 8'hD8, 8'hDF, 8'hEF, 8'hFA, 8'h10};
    logic [7:0]  dlt [4] = '{8'h00, 8'h38, 8'h10, 8'h10};
    int          off [4] = '{16, 16, 2, 3};
    logic        hit [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

    aamc_top uut (.SYS_CLK(sys_clk), .RST(rst), .CE(1'b1), .REG_ADDR(addr),
        .REG_WR(wr), .REG_WDATA(wd), .REG_RD(rd), .REG_RDATA(rdata),
        .POWER_MODE(mode), .MINUTE_TICK(tick), .PLL_FAULT_SET(pset),
        .PLL_FAULT_INDICATION(pll), .LOW_BATT_IRQ_ENABLE(pen),
        .LOW_BATT_FLAG_CLR(fclr), .LOW_BATT_FLAG(flag), .POWER_IRQ(pirq),
        .TEMP_REQ(tq), .TEMP_ACK(ta), .TEMP_DONE(tn), .TEMP_DATA(td),
        .TEMP_IRQ(ti), .BATT_REQ(bq), .BATT_ACK(ba), .BATT_DONE(bn),
        .BATT_DATA(bd), .BATT_IRQ(bi), .EXT_REQ(eq), .EXT_ACK(ea),
        .EXT_DONE(en), .EXT_DATA(ed), .EXT_IRQ(ei));
    aamc_conv_model tcv (.clk(sys_clk), .rst(rst), .slow(slow), .req(tq),
        .sample(ts), .ack(ta), .done(tn), .data(td));
    aamc_conv_model bcv (.clk(sys_clk), .rst(rst), .slow(slow), .req(bq),
        .sample(bs), .ack(ba), .done(bn), .data(bd));
    aamc_conv_model ecv (.clk(sys_clk), .rst(rst), .slow(slow), .req(eq),
        .sample(es), .ack(ea), .done(en), .data(ed));

    always #10 sys_clk = ~sys_clk;
    // A hang is cut short well beyond the fewer than a thousand cycles needed
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic sig(input int s);
        case (s)
            0: return ti;
            1: return bi;
            2: return ei;
            default: return bn;
        endcase
    endfunction : sig
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1;
        @(posedge sys_clk);
        #1 wr = 0;
        // Idle edge: a following call never lowers and raises at once
        @(posedge sys_clk);
        #1;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        rd = 1;
        @(posedge sys_clk);
        #1 rd = 0;
        chk(rdata, e);
        @(posedge sys_clk);
        #1;
    endtask : rd_chk
    task automatic wt(input int s, input int lim);
        got = 0;
        repeat (lim) begin
            @(posedge sys_clk);
            #1 if (got !== 1'b1) got = sig(s);
        end
    endtask : wt
    task automatic tk;
        tick = 1;
        @(posedge sys_clk);
        #1 tick = 0;
    endtask : tk
    task automatic single(input int s, input logic [7:0] smp);
        case (s)
            0: ts = smp;
            1: bs = smp;
            default: es = smp;
        endcase
        wr_reg(8'hD8, (s == 0) ? 8'h02 : (s == 1) ? 8'h01 : 8'h04);
        wt(s, 40);
        chk({7'h00, got}, 8'h01);
        rd_chk(8'hD8, 8'h00);
        rd_chk((s == 0) ? 8'hD7 : (s == 1) ? 8'hDF : 8'hEF, smp);
    endtask : single
    task automatic end_sim;
        if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    initial begin
        repeat (4) @(posedge sys_clk);
        #1 rst = 0;
        foreach (ra[i]) rd_chk(ra[i], 8'h00);
        pset = 1;
        @(posedge sys_clk);
        #1 pset = 0;
        chk({7'h00, pll}, 8'h01);
        wr_reg(8'hD8, 8'h80);
        @(posedge sys_clk);
        #1 chk({7'h00, pll}, 8'h00);
        tk();
        wt(0, 30);
        chk({7'h00, got}, 8'h00);
        wr_reg(8'hFA, 8'h40);
        rd_chk(8'hFA, 8'h40);
        for (int i = 0; i < 6; i++) begin
            lf = lfsr_next(lf);
            slow = lf[9];
            single(i % 3, lf[7:0]);
        end
        chk({6'h00, flag, pirq}, 8'h03);
        m_temp = ts;
        dir = (m_temp >= 128) ? -1 : 1;
        wr_reg(8'hF3, 8'h00);
        wr_reg(8'hF9, 8'h03);
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'hF3, dlt[i]);
            ts = 8'(m_temp + dir * off[i]);
            tk();
            wt(0, 40);
            chk({7'h00, got}, {7'h00, hit[i]});
            if (hit[i]) m_temp = ts;
            rd_chk(8'hD7, 8'(m_temp));
        end
        fclr = 1;
        @(posedge sys_clk);
        #1 fclr = 0;
        wr_reg(8'hF9, 8'h0F);
        for (int i = 0; i < 2; i++) begin
            bs = 8'h40 - 8'(i);
            tk();
            wt(3, 40);
            chk({7'h00, flag}, 8'(i));
        end
        chk({7'h00, pirq}, 8'h01);
        pen = 0;
        @(posedge sys_clk);
        #1 chk({7'h00, pirq}, 8'h00);
        rd_chk(8'hDF, 8'h3F);
        mode = 2'h2;
        wr_reg(8'hD8, 8'h02);
        wt(0, 30);
        chk({7'h00, got}, 8'h00);
        bs = 8'h00;
        tk();
        wt(3, 40);
        chk({7'h00, got}, 8'h00);
        mode = 2'h1;
        ts = 8'(m_temp) ^ 8'h80;
        tk();
        wt(0, 40);
        chk({7'h00, got}, 8'h00);
        end_sim();
    end
endmodule : tb_aux_adc_measurement_control
